// file: logic/sld_pkg.sv
// Package for the twelve-channel serial latched display driver.
// Assumes a single 50 MHz system clock and synchronous active-low reset.
`default_nettype none

package sld_pkg;

    // Number of channels, shift stages, hold cells and driver outputs.
    localparam int unsigned CHANNELS = 12;
    // Depth of the pin synchroniser.
    localparam int unsigned SYNC_DEPTH = 3;
    // Value of shift stages and hold cells after reset.
    localparam logic [11:0] STAGES_RESET = 12'h000;
    // Synchroniser value after reset; the gate input idles high, so outputs stay low.
    localparam logic [3:0] PINS_RESET = 4'h8;
    // Clock period in nanoseconds, for reference by the bench.
    localparam int unsigned CLK_PERIOD_NS = 20;

    // Control pins as they arrive from the controller.
    typedef struct packed {
        logic gate_n;    // Active-low output gate.
        logic latch_en;  // Latch enable, high means transparent.
        logic shift_clk; // Shift clock, rising edge shifts.
        logic data_in;   // Serial data input.
    } sld_pins_t;

endpackage : sld_pkg

`default_nettype wire

// file: logic/sld_pin_sync.sv
// Three-stage synchroniser with agreement filter for the four control pins.
// Assumes the pins are asynchronous to ref_clk and change slower than the clock.
`timescale 1ns/1ps
`default_nettype none

module sld_pin_sync (
    input wire logic ref_clk,             // System clock.
    input wire logic rst_n,               // Synchronous reset, active low.
    input wire sld_pkg::sld_pins_t pins,  // Raw pin levels.
    output sld_pkg::sld_pins_t clean      // Filtered, registered pin levels.
);

    logic [3:0] s1_ff, s2_ff, s3_ff, clean_ff;
    logic [3:0] nxt_clean;

    // A bit changes only when the second and third stage agree, which costs a clock of delay
    // but rejects a level caught mid-change; the first stage is read by the second alone.
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            nxt_clean[i] = (s2_ff[i] == s3_ff[i]) ? s2_ff[i] : clean_ff[i];
        end
    end

    // Registers for the chain and the filtered output.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            s1_ff <= sld_pkg::PINS_RESET;
            s2_ff <= sld_pkg::PINS_RESET;
            s3_ff <= sld_pkg::PINS_RESET;
            clean_ff <= sld_pkg::PINS_RESET;
        end
        else
        begin
            s1_ff <= pins;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            clean_ff <= nxt_clean;
        end
    end

    assign clean = clean_ff;

endmodule : sld_pin_sync

`default_nettype wire

// file: logic/sld_driver.sv
// Twelve-channel serial-in display driver: shift stages, hold cells, gated outputs.
// Assumes the controller pins are asynchronous and far slower than the 50 MHz ref_clk.
// Assumes rst_n is held low for at least two clocks before the controller starts.
// Every pin passes the three-flop filter, so each effect shows five clocks after its pin.
`timescale 1ns/1ps
`default_nettype none

module sld_driver (
    input wire logic ref_clk,                // System clock, 50 MHz.
    input wire logic rst_n,                  // Synchronous reset, active low.
    input wire logic data_in,                // Serial data pin.
    input wire logic shift_clk,              // Shift clock pin, rising edge shifts.
    input wire logic latch_en,               // Latch enable pin, high is transparent.
    input wire logic gate_n,                 // Output gate pin, active low.
    output logic [11:0] driver_outputs,      // Gated channel outputs.
    output logic serial_out                  // Cascade output from stage twelve.
);

    // Raw and filtered pin words, the datapath registers and the one-clock edge strobe.
    sld_pkg::sld_pins_t raw_pins;
    sld_pkg::sld_pins_t pins;
    logic [11:0] shift_stages_ff, nxt_shift_stages;
    logic [11:0] hold_cells_ff, nxt_hold_cells;
    logic [11:0] outputs_ff, nxt_outputs;
    logic clk_prev_ff, nxt_clk_prev;
    logic shift_edge;

    // Pins are packed into one word so they all take the same path through the filter.
    assign raw_pins = '{
        gate_n: gate_n,
        latch_en: latch_en,
        shift_clk: shift_clk,
        data_in: data_in
    };

    // All pins share one synchroniser so they keep their relative timing; a pin that
    // skipped it could reach the datapath a few clocks ahead of the shift clock.
    sld_pin_sync u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pins(raw_pins),
        .clean(pins)
    );

    // Edge detect works on the filtered clock, never on the first flop.
    // One strobe per rising edge; a slow pin has already been settled by the filter.
    assign shift_edge = pins.shift_clk && !clk_prev_ff;

    // Next state of the shift stages and the edge detector.
    always_comb
    begin
        nxt_clk_prev = pins.shift_clk;
        nxt_shift_stages = shift_stages_ff;
        if (shift_edge)
        begin
            nxt_shift_stages = {shift_stages_ff[10:0], pins.data_in};
        end
    end

    // Hold cells read the next stage values, so an open latch passes a shift in the same
    // clock as the stages. The price is that latch_en must share the filter with shift_clk,
    // or a closing latch could catch a word in the middle of a shift.
    always_comb
    begin
        if (pins.latch_en)
        begin
            nxt_hold_cells = nxt_shift_stages;
        end
        else
        begin
            nxt_hold_cells = hold_cells_ff;
        end
    end

    // Outputs are the AND of each hold cell with the active gate.
    // Reading the next hold values keeps the outputs in step with the cells they show.
    always_comb
    begin
        if (!pins.gate_n)
        begin
            nxt_outputs = nxt_hold_cells;
        end
        else
        begin
            nxt_outputs = sld_pkg::STAGES_RESET;
        end
    end

    // Registers for the whole datapath. The pins carry no reset of their own, so rst_n
    // only brings the block to a known dark state. The edge detector resets to the idle
    // level of the shift clock, so the release of reset cannot fake a rising edge.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            shift_stages_ff <= sld_pkg::STAGES_RESET;
            hold_cells_ff <= sld_pkg::STAGES_RESET;
            outputs_ff <= sld_pkg::STAGES_RESET;
            clk_prev_ff <= sld_pkg::PINS_RESET[1]; // Idle level of shift_clk.
        end
        else
        begin
            shift_stages_ff <= nxt_shift_stages;
            hold_cells_ff <= nxt_hold_cells;
            outputs_ff <= nxt_outputs;
            clk_prev_ff <= nxt_clk_prev;
        end
    end

    // Both outputs come straight from flip-flops, so they never glitch between clocks.
    assign driver_outputs = outputs_ff;
    // Serial output bypasses latch and gate so cascades keep shifting when outputs are blanked.
    assign serial_out = shift_stages_ff[11];

    // Checks on the filtered pins and the registered datapath. Every property samples
    // the filtered pins, so each one lines up with the clock in which the logic acts.
    // Reset disables them all; the state is cleared then and nothing is claimed.

    // A rising edge moves stages one to eleven up by one.
    a_shift_moves: assert property (@(posedge ref_clk) disable iff (!rst_n)
        shift_edge |=> shift_stages_ff[11:1] == $past(shift_stages_ff[10:0]))
        else $error("Shift stages did not advance on shift edge.");

    // Stage one takes the serial data bit of that same edge.
    a_first_stage: assert property (@(posedge ref_clk) disable iff (!rst_n)
        shift_edge |=> shift_stages_ff[0] == $past(pins.data_in))
        else $error("First stage missed serial data.");

    // Without an edge the stages keep their data.
    a_no_edge_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !shift_edge |=> $stable(shift_stages_ff))
        else $error("Shift stages changed without an edge.");

    // An open latch passes every stage to its hold cell.
    a_latch_open: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pins.latch_en |=> hold_cells_ff == shift_stages_ff)
        else $error("Open latch does not follow the stages.");

    // Latch enable low in two clocks in a row.
    sequence s_latch_closed;
        !pins.latch_en ##1 !pins.latch_en;
    endsequence

    // A closed latch keeps its data whatever the stages do.
    a_latch_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_latch_closed |=> $stable(hold_cells_ff))
        else $error("Closed latch changed its data.");

    // Latch enable falls: open in one clock, closed in the next.
    sequence s_latch_fall;
        pins.latch_en ##1 !pins.latch_en;
    endsequence

    // After the fall the hold cells keep the word that stood in the stages as it fell.
    a_latch_capture: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_latch_fall |=> hold_cells_ff == $past(shift_stages_ff))
        else $error("Hold cells lost the word present when latch enable fell.");

    // A shift edge that meets an open latch.
    sequence s_open_shift;
        shift_edge && pins.latch_en;
    endsequence

    // The first hold cell takes the new data bit in the same clock as stage one.
    a_open_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_open_shift |=> hold_cells_ff[0] == $past(pins.data_in))
        else $error("Open latch did not pass the new first stage.");

    // The gate low shows each hold cell on its own output.
    a_gate_open: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !pins.gate_n |=> driver_outputs == hold_cells_ff)
        else $error("Outputs do not follow hold cells with gate low.");

    // The gate high forces every output low.
    a_gate_blank: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pins.gate_n |=> driver_outputs == 12'h000)
        else $error("Outputs not low with gate high.");

    // The gate opens again after blanking: high in one clock, low in the next.
    sequence s_gate_opens;
        pins.gate_n ##1 !pins.gate_n;
    endsequence

    // Blanking loses nothing: the outputs return to the hold cells at once.
    a_gate_return: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_gate_opens |=> driver_outputs == hold_cells_ff)
        else $error("Outputs did not return to the hold cells after blanking.");

    // Latch closed and gate low in two clocks in a row.
    sequence s_shown_steady;
        (!pins.latch_en && !pins.gate_n) ##1 (!pins.latch_en && !pins.gate_n);
    endsequence

    // Nothing may move the lit outputs while the latch stays closed.
    a_shown_steady: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_shown_steady |=> $stable(driver_outputs))
        else $error("Outputs moved with the latch closed and the gate low.");

    // With the latch open and the gate low a shift reaches the outputs in one clock.
    a_open_path: assert property (@(posedge ref_clk) disable iff (!rst_n)
        shift_edge && pins.latch_en && !pins.gate_n |=> driver_outputs == shift_stages_ff)
        else $error("Shift did not reach the outputs through the open latch.");

    // Blanking the outputs leaves the hold cells alone.
    a_blank_keeps: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pins.gate_n && !pins.latch_en |=> $stable(hold_cells_ff))
        else $error("Hold cells changed while the outputs were blanked.");

    // Serial output follows stage twelve across an edge.
    a_serial_tail: assert property (@(posedge ref_clk) disable iff (!rst_n)
        shift_edge |=> serial_out == $past(shift_stages_ff[10]))
        else $error("Serial output does not track stage twelve.");

    // Between edges the serial output stands still, whatever latch enable and gate do.
    a_serial_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !shift_edge |=> $stable(serial_out))
        else $error("Serial output moved without a shift edge.");

endmodule : sld_driver

`default_nettype wire

// file: test/sld_ctrl_model.sv
// Display controller model: shifts words, pulses latch enable, drives the gate.
// Assumes ref_clk runs at 50 MHz; every pin change lands 1 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module sld_ctrl_model (
    input wire logic ref_clk,       // System clock.
    output var sld_pkg::sld_pins_t pins // Pin levels toward the driver.
);
    // Idle pins: gate high keeps the outputs dark until the bench opens it.
    initial
    begin
        pins = sld_pkg::PINS_RESET;
    end

    // Six clocks per phase, one more than the pin filter needs to settle.
    task automatic hold_phase();
        repeat (6) @(posedge ref_clk);
        #1;
    endtask : hold_phase

    // Shifts the top count bits of word, far channel first.
    task automatic send_bits(input logic [11:0] word, input int count);
        for (int i = 11; i > 11 - count; i--)
        begin
            pins.data_in = word[i];
            hold_phase();
            pins.shift_clk = 1'b1;
            hold_phase();
            pins.shift_clk = 1'b0;
            pins.data_in = ~word[i]; // Hold time is over, so the old bit is not kept.
            hold_phase();
        end
    endtask : send_bits

    // Latch enable level; the bench keeps it low while shifting whole words.
    task automatic latch(input logic level);
        pins.latch_en = level;
        hold_phase();
    endtask : latch

    // Output gate level, low lights the outputs.
    task automatic gate(input logic level);
        pins.gate_n = level;
        hold_phase();
    endtask : gate
endmodule : sld_ctrl_model

`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the twelve-channel serial latched display driver.
// Assumes the controller model drives all pins and results settle within a phase.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("FAIL %s exp %h got %h", n, e, g); end end

module tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    sld_pkg::sld_pins_t pins;
    logic [11:0] driver_outputs;
    logic serial_out;
    int mismatches = 0;
    int tests_run = 0;
    int seed = 77033;
    logic [11:0] stages = 12'h000;
    logic [11:0] cells = 12'h000;
    logic [11:0] word = 12'h000;
    logic gate_n = 1'b1;
    logic [12:0] notes[$];
    event settled;

    // Free-running 50 MHz clock.
    always #10 ref_clk = ~ref_clk;

    sld_ctrl_model i_sld_ctrl_model (.ref_clk(ref_clk), .pins(pins));

    sld_driver i_sld_driver (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .data_in(pins.data_in),
        .shift_clk(pins.shift_clk),
        .latch_en(pins.latch_en),
        .gate_n(pins.gate_n),
        .driver_outputs(driver_outputs),
        .serial_out(serial_out)
    );

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("Checks run %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test

    // Notes the expected pins from the bench's own copy of stages and cells.
    task automatic note();
        notes.push_back({stages[11], gate_n ? 12'h000 : cells});
        -> settled;
    endtask : note

    // Each settle event retires the oldest note against the outputs.
    initial
    begin
        logic [12:0] exp_val;
        forever
        begin
            @(settled);
            exp_val = notes.pop_front();
            `CHK("serial_out", exp_val[12], serial_out)
            `CHK("driver_outputs", exp_val[11:0], driver_outputs)
        end
    end

    // Cuts a hang short well beyond the expected run length.
    initial
    begin
        #(20 * 6000);
        mismatches++;
        stop_test();
    end

    // Random words through shift, latch, transparent shift and gate phases.
    initial
    begin
        repeat (16) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        i_sld_ctrl_model.gate(1'b0);
        gate_n = 1'b0;
        for (int k = 0; k < 6; k++)
        begin
            word = 12'($random(seed));
            i_sld_ctrl_model.send_bits(word, 12);
            stages = word;
            note();
            i_sld_ctrl_model.latch(1'b1);
            cells = stages;
            note();
            i_sld_ctrl_model.send_bits(~word, 1);
            stages = {stages[10:0], ~word[11]};
            cells = stages;
            note();
            i_sld_ctrl_model.latch(1'b0);
            i_sld_ctrl_model.gate(1'b1);
            gate_n = 1'b1;
            note();
            i_sld_ctrl_model.gate(1'b0);
            gate_n = 1'b0;
        end
        stop_test();
    end
endmodule : tb

`default_nettype wire
